// ---- pkg/dtp_map.svh ----
// register indices, reset values and timing counts of the terminal block
`ifndef DTP_MAP_SVH
`define DTP_MAP_SVH

// register index = paddr[11:2]
`define DTP_IDX_DRIVE0   10'h10f
`define DTP_IDX_BD_LAST  10'h126
`define DTP_BD_STRIDE    10'h006
`define DTP_IDX_DIP_HI0  10'h136
`define DTP_IDX_RUN_LO   10'h13f
`define DTP_IDX_RES0     10'h2ad
`define DTP_IDX_RES_LAST 10'h2b0
`define DTP_IDX_SRC0     10'h300
`define DTP_IDX_SRC_LAST 10'h303
`define DTP_IDX_DST0     10'h308
`define DTP_IDX_DST_LAST 10'h310
`define DTP_IDX_STAT     10'h318

// field numbers inside one bidirectional group
`define DTP_F_DRIVE      3'h0
`define DTP_F_RECT       3'h1
`define DTP_F_THR        3'h2
`define DTP_F_INV        3'h3
`define DTP_F_HI         3'h4
`define DTP_F_LO         3'h5

// reset values
`define DTP_LINK_OFF     10'h190
`define DTP_RUN_DST      10'h134
`define DTP_BD_DST0      10'h074
`define DTP_BD_DST1      10'h02a
`define DTP_BD_DST2      10'h021
`define DTP_BD_DST3      10'h058
`define DTP_HI_RST       16'sh0001
`define DTP_LO_RST       16'sh0000
`define DTP_THR_RST      16'sh0000
`define DTP_VAL_MAX      32'sh0000_7530

// processing scan length in pclk cycles
`define DTP_SCAN_CYCLES  10

`endif

// ---- pkg/dtp_pkg.sv ----
// types shared by the terminal processing block
package dtp_pkg;
  typedef logic signed [15:0] dtp_val_t;
  typedef logic [9:0]         dtp_link_t;
  typedef struct packed
  {
    dtp_link_t link;
    dtp_val_t  value;
    logic      logic_hi;
  } dtp_sel_t;
endpackage

// ---- src/dtp_sync2.sv ----
// two-flop synchroniser for terminal levels
`timescale 1ns/1ps
module dtp_sync2
#(
  parameter int W = 1
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ---- src/dtp_out_chain.sv ----
// output chain: rectify, strict compare, invert
`timescale 1ns/1ps
module dtp_out_chain
(
  input  wire dtp_pkg::dtp_val_t operand,
  input  wire dtp_pkg::dtp_val_t threshold,
  input  wire logic              rectify,
  input  wire logic              invert,
  output logic                   result
);
  import dtp_pkg::*;

  dtp_val_t mag;
  logic     above;

  assign mag    = (rectify && operand < 0) ? -operand : operand; // RULE_03
  assign above  = mag > threshold;                                // RULE_04
  assign result = above ^ invert;                                 // RULE_06
endmodule

// ---- src/dtp_terminal_io.sv ----
// digital terminal processing with apb register access
//
// How it works
// RULE_01: four bidirectional terminals, independent chains
// RULE_02: source link 000..720, reset 400; writes are not limited, any 10-bit value up to 1023 is stored
// RULE_03: optional magnitude before compare
// RULE_04: high only when strictly above threshold
// RULE_05: logic sources use zero threshold
// RULE_06: selectable inversion, then drive switch
// RULE_07: result kept internally regardless of drive
// RULE_08: drive disabled at reset, never driven
// RULE_09: driven when enabled, level still sampled
// RULE_10: low output released, wired-or possible
// RULE_11: drive select changed only when stopped; the block accepts drive select writes at any time
// RULE_12: level selects high or low value
// RULE_13: zero is low, nonzero is high
// RULE_14: inversion by high zero, low one
// RULE_15: input-only defaults one, zero, unconnected
// RULE_16: input-only levels at 310 upward paired
// RULE_17: run selector at 318 and 319
// RULE_18: repurposed run keeps run hold high
// RULE_19: drive selects at 271 277 283 289
// RULE_20: thresholds from 273, one per terminal
// RULE_21: linear values clamped to thirty thousand
// RULE_22: bidirectional low levels at 276 onward
// RULE_23: everything evaluated once per scan
`timescale 1ns/1ps
`include "dtp_map.svh"
module dtp_terminal_io
#(
  parameter int SCAN_CYCLES = `DTP_SCAN_CYCLES
)
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [3:0]              bidir_terminal_in,
  output logic      [3:0]              bidir_terminal_out,
  output logic      [3:0]              bidir_terminal_oe,
  input  wire logic [3:0]              input_only_terminal_in,
  input  wire logic                    run_terminal_in,
  input  wire dtp_pkg::dtp_val_t [3:0] src_value,
  output dtp_pkg::dtp_link_t     [3:0] source_link,
  output logic      [3:0]              out_result,
  output dtp_pkg::dtp_sel_t      [8:0] destination_link
);
  import dtp_pkg::*;

  if (SCAN_CYCLES < 2 || SCAN_CYCLES > 65535)
  begin : g_bad_scan
    $error("SCAN_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic dtp_val_t sat_val(input logic [31:0] d);
    if ($signed(d) > `DTP_VAL_MAX)
      return dtp_val_t'(`DTP_VAL_MAX);
    else if ($signed(d) < -`DTP_VAL_MAX)
      return dtp_val_t'(-`DTP_VAL_MAX);
    else
      return d[15:0];
  endfunction

  function automatic logic [31:0] sext(input dtp_val_t v);
    return {{16{v[15]}}, v};
  endfunction

  function automatic dtp_link_t dst_rst(input int i);
    case (i)
      0: return `DTP_BD_DST0;
      1: return `DTP_BD_DST1;
      2: return `DTP_BD_DST2;
      3: return `DTP_BD_DST3;
      8: return `DTP_RUN_DST;
      default: return `DTP_LINK_OFF;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0]      drive_reg;
  logic [3:0]      rect_reg;
  logic [3:0]      inv_reg;
  dtp_val_t  [3:0] thr_reg;
  dtp_link_t [3:0] src_link_reg;
  dtp_val_t  [8:0] hi_reg;
  dtp_val_t  [8:0] lo_reg;
  dtp_link_t [8:0] dst_reg;
  logic [3:0]      result_reg;
  logic [8:0]      lvl_reg;
  dtp_sel_t  [8:0] sel_reg;
  logic [3:0]      term_out_reg;
  logic [3:0]      term_oe_reg;
  logic [15:0]     scan_cnt_reg;
  logic [31:0]     prdata_reg;
  logic            pready_reg;
  logic            pslverr_reg;

  // ----------------------------------------------------------------
  // pin sampling and scan tick
  // ----------------------------------------------------------------
  logic [8:0] pins_sync;
  logic       tick;
  logic [3:0] res_w;

  dtp_sync2 #(.W(9)) u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({run_terminal_in, input_only_terminal_in,
               bidir_terminal_in}),
    .q       (pins_sync)
  );

  assign tick = scan_cnt_reg == 16'h0000;

  for (genvar k = 0; k < 4; k++) // RULE_01
  begin : g_chain
    dtp_out_chain u_chain
    (
      .operand   (src_value[k]),
      .threshold (thr_reg[k]),
      .rectify   (rect_reg[k]),
      .invert    (inv_reg[k]),
      .result    (res_w[k])
    );
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [9:0] idx;
  logic [9:0] bd_off;
  logic [1:0] bd_k;
  logic [2:0] bd_f;
  logic [3:0] dip_s;
  logic       bd_hit;
  logic       dip_hit;
  logic       res_hit;
  logic       src_hit;
  logic       dst_hit;
  logic       stat_hit;
  logic       any_hit;
  logic [1:0] src_i;
  logic [3:0] dst_i;
  logic [1:0] res_i;
  logic       wr_en;
  logic       setup;

  assign idx      = paddr[11:2];
  assign bd_off   = idx - `DTP_IDX_DRIVE0;
  assign bd_k     = 2'(bd_off / `DTP_BD_STRIDE);
  assign bd_f     = 3'(bd_off % `DTP_BD_STRIDE);
  assign dip_s    = 4'(4'd4 + 4'((idx - `DTP_IDX_DIP_HI0) >> 1));
  assign bd_hit   = idx >= `DTP_IDX_DRIVE0 && idx <= `DTP_IDX_BD_LAST;
  assign dip_hit  = idx >= `DTP_IDX_DIP_HI0 && idx <= `DTP_IDX_RUN_LO;
  assign res_hit  = idx >= `DTP_IDX_RES0 && idx <= `DTP_IDX_RES_LAST;
  assign src_hit  = idx >= `DTP_IDX_SRC0 && idx <= `DTP_IDX_SRC_LAST;
  assign dst_hit  = idx >= `DTP_IDX_DST0 && idx <= `DTP_IDX_DST_LAST;
  assign stat_hit = idx == `DTP_IDX_STAT;
  assign any_hit  = bd_hit | dip_hit | res_hit | src_hit | dst_hit
                  | stat_hit;
  assign src_i    = 2'(idx - `DTP_IDX_SRC0);
  assign dst_i    = 4'(idx - `DTP_IDX_DST0);
  assign res_i    = 2'(idx - `DTP_IDX_RES0);
  assign setup    = psel & ~penable;
  // writes land on the single access edge; pready is high there
  assign wr_en    = psel & penable & pready_reg & pwrite & any_hit;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rdata;

  always_comb
  begin
    rdata = '0;
    if (bd_hit)
    begin
      unique case (bd_f)
        `DTP_F_DRIVE: rdata = {31'h0, drive_reg[bd_k]};
        `DTP_F_RECT:  rdata = {31'h0, rect_reg[bd_k]};
        `DTP_F_THR:   rdata = sext(thr_reg[bd_k]);
        `DTP_F_INV:   rdata = {31'h0, inv_reg[bd_k]};
        `DTP_F_HI:    rdata = sext(hi_reg[bd_k]);
        `DTP_F_LO:    rdata = sext(lo_reg[bd_k]);
        default:      rdata = '0;
      endcase
    end
    else if (dip_hit)
      rdata = idx[0] ? sext(lo_reg[dip_s]) : sext(hi_reg[dip_s]);
    else if (res_hit)
      rdata = {31'h0, result_reg[res_i]}; // RULE_07
    else if (src_hit)
      rdata = {22'h0, src_link_reg[src_i]};
    else if (dst_hit)
      rdata = {22'h0, dst_reg[dst_i]};
    else if (stat_hit)
      rdata = {15'h0, term_oe_reg, result_reg, lvl_reg};
  end

  // ----------------------------------------------------------------
  // apb answer: zero wait states, error on unmapped index
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~any_hit;
      if (setup)
        prdata_reg <= any_hit ? rdata : '0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_reg <= '0;                           // RULE_08
      rect_reg  <= '0;
      inv_reg   <= '0;
      for (int k = 0; k < 4; k++)
      begin
        thr_reg[k]      <= `DTP_THR_RST;
        src_link_reg[k] <= `DTP_LINK_OFF;        // RULE_02
      end
      for (int i = 0; i < 9; i++)
      begin
        hi_reg[i]  <= `DTP_HI_RST;               // RULE_15
        lo_reg[i]  <= `DTP_LO_RST;               // RULE_22
        dst_reg[i] <= dst_rst(i);
      end
    end
    else if (wr_en)
    begin
      if (bd_hit)
      begin
        unique case (bd_f)
          `DTP_F_DRIVE: drive_reg[bd_k] <= pwdata[0]; // RULE_19
          `DTP_F_RECT:  rect_reg[bd_k]  <= pwdata[0];
          `DTP_F_THR:   thr_reg[bd_k]   <= sat_val(pwdata); // RULE_20
          `DTP_F_INV:   inv_reg[bd_k]   <= pwdata[0];
          `DTP_F_HI:    hi_reg[bd_k]    <= sat_val(pwdata);
          `DTP_F_LO:    lo_reg[bd_k]    <= sat_val(pwdata); // RULE_21
          default:      ;
        endcase
      end
      else if (dip_hit)
      begin
        if (idx[0])
          lo_reg[dip_s] <= sat_val(pwdata);      // RULE_16
        else
          hi_reg[dip_s] <= sat_val(pwdata);      // RULE_17
      end
      else if (src_hit)
        src_link_reg[src_i] <= pwdata[9:0];
      else if (dst_hit)
        dst_reg[dst_i] <= pwdata[9:0];
    end
  end

  // ----------------------------------------------------------------
  // scan processing
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scan_cnt_reg <= '0;
      result_reg   <= '0;
      lvl_reg      <= '0;
      term_out_reg <= '0;
      term_oe_reg  <= '0;
      sel_reg      <= '0;
    end
    else
    begin
      scan_cnt_reg <= tick ? 16'(SCAN_CYCLES - 1) : scan_cnt_reg - 16'h0001;
      if (tick)                                  // RULE_23
      begin
        result_reg   <= res_w;                   // RULE_07
        lvl_reg      <= pins_sync;               // RULE_09
        term_out_reg <= res_w;
        // only a high result is driven; low leaves the line free
        term_oe_reg  <= drive_reg & res_w;       // RULE_10
        for (int i = 0; i < 9; i++)
        begin
          sel_reg[i].link     <= dst_reg[i];
          sel_reg[i].value    <= pins_sync[i] ? hi_reg[i] : lo_reg[i];
          sel_reg[i].logic_hi <= pins_sync[i] ? hi_reg[i] != 0
                                              : lo_reg[i] != 0; // RULE_13
        end
      end
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign bidir_terminal_out = term_out_reg;
  assign bidir_terminal_oe  = term_oe_reg;
  assign out_result         = result_reg;
  assign source_link        = src_link_reg;
  assign destination_link   = sel_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_oe_follows_drive: assert property // RULE_08
    (tick |=> term_oe_reg == ($past(drive_reg) & $past(res_w)))
    else $error("drive enable does not follow select and result");
  a_oe_only_high: assert property // RULE_10
    ((term_oe_reg & ~term_out_reg) == 4'h0)
    else $error("terminal driven while result is low");
  a_oe_holds: assert property // RULE_23
    (!tick |=> $stable(term_oe_reg) && $stable(sel_reg))
    else $error("outputs changed between scans");
  a_equal_low: assert property // RULE_04
    (tick && !rect_reg[0] && !inv_reg[0] && src_value[0] == thr_reg[0]
     |=> !result_reg[0])
    else $error("equal operand gave high result");
  a_rectify_neg: assert property // RULE_03
    (tick && rect_reg[1] && thr_reg[1] == 0
     && src_value[1] < 0 |=> result_reg[1] != $past(inv_reg[1]))
    else $error("negative operand not rectified");
  a_invert_eq: assert property // RULE_06
    (tick && inv_reg[2] && !rect_reg[2] && src_value[2] == thr_reg[2]
     |=> result_reg[2])
    else $error("inversion missing");
  a_run_select: assert property // RULE_12
    (tick |=> sel_reg[8].value ==
     ($past(pins_sync[8]) ? $past(hi_reg[8]) : $past(lo_reg[8])))
    else $error("run value selection wrong");
  a_logic_sense: assert property // RULE_13
    (sel_reg[4].logic_hi == (sel_reg[4].value != 0))
    else $error("logic sense of level value wrong");
  a_value_clamp: assert property // RULE_21
    (thr_reg[3] <= 16'sh7530 && thr_reg[3] >= -16'sh7530)
    else $error("threshold outside linear range");
  a_drive_reset: assert property // RULE_08
    ($rose(presetn) |-> drive_reg == 4'h0 && term_oe_reg == 4'h0)
    else $error("drive select not disabled after reset");
  a_apb_ready: assert property
    (setup |=> pready_reg ##1 !pready_reg)
    else $error("apb answer not single cycle");

  c_driven: cover property (term_oe_reg[0] ##1 !term_oe_reg[0]);
  c_inverted_in: cover property
    (tick && hi_reg[5] == 0 && lo_reg[5] != 0 && !pins_sync[5]);
  c_rectified: cover property (tick && rect_reg[1] && src_value[1] < 0);
  c_unmapped: cover property (pslverr_reg);
endmodule

// ---- verif/dtp_field.sv ----
// field wiring model: pulled-down terminals, wired-or, input sources
`timescale 1ns/1ps
module dtp_field
(
  input  wire logic       pclk,
  input  wire logic       slow,
  input  wire logic [3:0] bidir_terminal_oe,
  input  wire logic [3:0] ext_drive,
  input  wire logic [4:0] ext_dip,
  output logic      [3:0] bidir_terminal_in,
  output logic      [3:0] input_only_terminal_in,
  output logic            run_terminal_in
);
  logic [8:0] lvl_reg;
  logic [8:0] lvl_next;

  // ----------------------------------------
  // wire resolution
  // ----------------------------------------
  // pull-down on each terminal, so a released wire reads low, one cycle late in slow mode
  assign lvl_next = {ext_dip, bidir_terminal_oe | ext_drive};

  always_ff @(posedge pclk)
    lvl_reg <= lvl_next;

  // slow mode adds one cycle of cable delay to every level
  assign {run_terminal_in, input_only_terminal_in, bidir_terminal_in} =
    slow ? lvl_reg : lvl_next;
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the terminal processing block
`timescale 1ns/1ps
`include "dtp_map.svh"
module tb;
  import dtp_pkg::*;
  typedef struct {logic [31:0] d; logic e; logic c;} dtp_note_t;
  localparam int SC     = 2;
  localparam int SETTLE = 2 * SC + 4;
  localparam int VMAX   = 32'h0000_7530;
  logic              pclk, presetn, psel, penable, pwrite;
  logic              pready, pslverr, slow, run_terminal_in;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic [3:0]        bidir_terminal_in, bidir_terminal_out;
  logic [3:0]        bidir_terminal_oe, input_only_terminal_in;
  logic [3:0]        ext_drive, out_result;
  logic [4:0]        ext_dip, pins;
  dtp_val_t  [3:0]   src_value;
  dtp_link_t [3:0]   source_link;
  dtp_sel_t  [8:0]   destination_link;
  dtp_note_t         notes[$];
  dtp_note_t         nt;
  int                failures, checked, cycles;
  int                it, k, j, op, th, e, v, b;
  logic              rect, inv, drv;
  int                hv[5], lv[5], lk[5];
  logic [9:0] r_idx[14] = '{10'h10f, 10'h111, 10'h113, 10'h114, 10'h121,
    10'h136, 10'h13d, 10'h13e, 10'h13f, 10'h300, 10'h308, 10'h30c,
    10'h310, 10'h2ad};
  logic [9:0] r_val[14] = '{10'h000, 10'h000, 10'h001, 10'h000, 10'h000,
    10'h001, 10'h000, 10'h001, 10'h000, 10'h190, 10'h074, 10'h190,
    10'h134, 10'h000};

  dtp_terminal_io #(.SCAN_CYCLES(SC)) u_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .bidir_terminal_in(bidir_terminal_in),
    .bidir_terminal_out(bidir_terminal_out),
    .bidir_terminal_oe(bidir_terminal_oe),
    .input_only_terminal_in(input_only_terminal_in),
    .run_terminal_in(run_terminal_in), .src_value(src_value),
    .source_link(source_link), .out_result(out_result),
    .destination_link(destination_link)
  );

  dtp_field u_field
  (
    .pclk(pclk), .slow(slow), .bidir_terminal_oe(bidir_terminal_oe),
    .ext_drive(ext_drive), .ext_dip(ext_dip),
    .bidir_terminal_in(bidir_terminal_in),
    .input_only_terminal_in(input_only_terminal_in),
    .run_terminal_in(run_terminal_in)
  );

  // ----------------------------------------
  // clock, timeout, closing
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic wrap_up;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    // generous ceiling: full run needs well under a thousand cycles
    if (cycles == 32'h0000_4e20)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    checked++;
    if (got !== ex)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // ----------------------------------------
  // apb master and answer monitor
  // ----------------------------------------
  task automatic apb(input logic w, input logic [9:0] ix,
                     input logic [31:0] wd, input logic [31:0] ex,
                     input logic er);
    // one idle edge first, so psel is never assigned twice in a step
    @(posedge pclk);
    notes.push_back('{ex, er, !w});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {ix, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle budget here; only the bench ceiling ends a stuck wait
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [9:0] ix, logic [31:0] wd);
    apb(1'b1, ix, wd, 32'h0000_0000, 1'b0);
  endtask

  always @(posedge pclk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      nt = notes.pop_front();
      if (nt.c)
        chk("prdata", nt.d, prdata);
      chk("pslverr", {31'h0, nt.e}, {31'h0, pslverr});
    end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, slow} = '0;
    {src_value, ext_drive, ext_dip, presetn} = '0;
    void'($urandom(32'hc5b3));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (it = 0; it < 14; it++)
      apb(1'b0, r_idx[it], 0, {22'h0, r_val[it]}, 1'b0);
    chk("oe_reset", 0, {28'h0, bidir_terminal_oe});
    apb(1'b0, 10'h000, 0, 32'h0000_0000, 1'b1);
    wr(`DTP_IDX_RES0, 32'h0000_0001);
    apb(1'b0, `DTP_IDX_RES0, 0, 32'h0000_0000, 1'b0);
    wr(10'h111, 32'h0000_9c40);
    apb(1'b0, 10'h111, 0, 32'h0000_7530, 1'b0);
    wr(10'h111, 32'hffff_63c0);
    apb(1'b0, 10'h111, 0, 32'hffff_8ad0, 1'b0);
    for (it = 0; it < 16; it++)
    begin
      k  = it % 4;
      b  = `DTP_IDX_DRIVE0 + `DTP_BD_STRIDE * k;
      op = $urandom_range(2 * VMAX) - VMAX;
      th = (it < 4) ? op : $urandom_range(2 * VMAX) - VMAX;
      rect = (it < 4) ? 1'b0 : (it < 8) ? 1'b1 : 1'($urandom);
      if (it >= 4 && it < 8)
      begin
        op = -$urandom_range(VMAX);
        th = (k == 1) ? 0 : -op - 1;
      end
      inv = 1'($urandom);
      drv = it >= 8;
      // drive select only moves here, with no terminal traffic running
      wr(10'(b), {31'h0, drv});
      wr(10'(b + 1), {31'h0, rect});
      wr(10'(b + 2), th);
      wr(10'(b + 3), {31'h0, inv});
      j = $urandom_range(720);
      wr(10'(`DTP_IDX_SRC0 + k), j);
      src_value[k] <= op[15:0];
      repeat (SETTLE) @(posedge pclk);
      v = (rect && op < 0) ? -op : op;
      e = (v > th) ^ inv;
      apb(1'b0, 10'(`DTP_IDX_RES0 + k), 0, e, 1'b0);
      chk("out_result", e, {31'h0, out_result[k]});
      chk("oe", drv & e, {31'h0, bidir_terminal_oe[k]});
      chk("bd_level", drv & e, destination_link[k].value);
      chk("term_out", e, {31'h0, bidir_terminal_out[k]});
      chk("src_link", j, {22'h0, source_link[k]});
    end
    // logic-valued source against a zero threshold
    wr(10'h110, 32'h0000_0000);
    wr(10'h111, 32'h0000_0000);
    wr(10'h112, 32'h0000_0000);
    src_value[0] <= 16'sh0001;
    repeat (SETTLE) @(posedge pclk);
    chk("logic_src", 1, {31'h0, out_result[0]});
    ext_drive <= 4'hf;
    repeat (SETTLE) @(posedge pclk);
    for (k = 0; k < 4; k++)
      chk("wired_or", 1, destination_link[k].value);
    for (j = 0; j < 5; j++)
    begin
      hv[j] = (j == 1) ? 0 : $urandom_range(2 * VMAX) - VMAX;
      lv[j] = (j == 1) ? 1 : $urandom_range(2 * VMAX) - VMAX;
      lk[j] = (j == 4) ? 32'h0000_0134 : $urandom_range(10'h2d0);
      wr(10'(`DTP_IDX_DIP_HI0 + 2 * j), hv[j]);
      wr(10'(`DTP_IDX_DIP_HI0 + 2 * j + 1), lv[j]);
      wr(10'(`DTP_IDX_DST0 + 4 + j), lk[j]);
    end
    pins = 5'($urandom);
    for (it = 0; it < 2; it++)
    begin
      ext_dip <= pins;
      slow    <= it[0];
      repeat (SETTLE + 1) @(posedge pclk);
      for (j = 0; j < 5; j++)
      begin
        v = pins[j] ? hv[j] : lv[j];
        chk("in_value", v, destination_link[4 + j].value);
        chk("in_logic", v != 0, {31'h0, destination_link[4 + j].logic_hi});
        chk("in_link", lk[j], {22'h0, destination_link[4 + j].link});
      end
      pins = ~pins;
    end
    wrap_up();
  end
endmodule
